// ===== verilog/ebl_defs.svh
// Constants for the EEPROM bulk access and fault log controller.
// Assumes inclusion by bare name from the design file.
`ifndef EBL_DEFS_SVH
`define EBL_DEFS_SVH

// Access key codes
`define EBL_KEY_OPEN        8'h2B
`define EBL_KEY_RW_PECOPT   8'hD4
`define EBL_KEY_RW_PECREQ   8'hD5
`define EBL_KEY_RD_STEP     8'h91
`define EBL_KEY_RD_PECOPT   8'hE4
`define EBL_KEY_RD_PECREQ   8'hE5
`define EBL_WIPE_CODE       8'h2B

// Memory geometry and contents
`define EBL_USER_WORDS      64
`define EBL_PTR_W           8
`define EBL_LOG_WORDS       16
`define EBL_LOG_FIRST_CYC   4'h2
`define EBL_LOG_PEAK_SLOT   0
`define EBL_LOG_MIN_SLOT    1
`define EBL_ERASED_WORD     16'hFFFF
`define EBL_REV_WORD        16'h0001
`define EBL_STATE_BUSYN_BIT 6
`define EBL_STATE_HELD_BIT  0
`define EBL_STATE_FROZ_BIT  1
`define EBL_FIFO_DEPTH      16
`define EBL_DATA_W          16

// Timing
`define EBL_CLK_MHZ         100
`define EBL_WORD_PROG_NS    170000
`define EBL_ERASE_MS        400

`endif

// ===== verilog/ebl_pkg.sv
// Types for the EEPROM bulk access and fault log controller.
// Assumes ebl_defs.svh sits on the include path.
package ebl_pkg;
  // Commands as decoded by the serial front end
  typedef enum logic [3:0] {
    EBL_CMD_STATE_RD, EBL_CMD_KEY_WR, EBL_CMD_KEY_RD, EBL_CMD_WIPE_WR,
    EBL_CMD_WIPE_RD, EBL_CMD_WORD_WR, EBL_CMD_WORD_RD, EBL_CMD_LOG_STORE,
    EBL_CMD_LOG_RESTORE, EBL_CMD_LOG_CLEAR, EBL_CMD_OTHER
  } ebl_cmd_e;

  // Access mode chosen by the unlock sequence
  typedef enum logic [1:0] {EBL_LOCKED, EBL_UNLOCK_RW, EBL_UNLOCK_RD} ebl_mode_e;

  // Progress through a key sequence
  typedef enum logic [1:0] {EBL_KEY_IDLE, EBL_KEY_OPENED, EBL_KEY_RDSTEP} ebl_key_e;
endpackage

// ===== verilog/ebl_bulk_access.sv
// EEPROM bulk access controller with fault log and sample FIFO.
// Assumes a serial front end that decodes byte/word commands into one-cycle
// requests, checks PEC, and NACKs when the answer carries ack low.
//
// Summary of operation
// - Key written as two or three bytes; any unsupported sequence locks.
// - Key 2B then D4 unlocks user space read/write, PEC optional.
// - Key 2B then D5 unlocks user space read/write, PEC mandatory.
// - Key 2B, 91, then E4 or E5 unlocks read only access.
// - Completing an unlock resets the word pointer.
// - Key read gives last byte written, zero while locked.
// - Wipe code 2B erases user space after read/write unlock; other values lock.
// - Wipe register read gives last value written.
// - Reads give revision word, word total, then data upward.
// - Read past last word returns zero and locks.
// - Writes after erase fill upward; write past end locks.
// - Word port goes straight to memory, working RAM untouched.
// - Busy flag low during memory access; state byte always answered.
// - Other commands while busy are refused and pull alert low.
// - Erase lasts about 400 ms; poll the busy flag.
// - RAM log buffer refreshed continuously with samples and peak/min.
// - Fault copies RAM log to memory and locks the stored log.
// - Store command copies RAM log to memory.
// - Restore copies stored log to RAM, freezing RAM until read or wipe.
// - Log wipe erases stored log and re-enables storing.
// - Log held flag survives reset; only log wipe clears it.
// - Quick log stores at once, else waits for fresh readings.
`timescale 1ns/1ps
`include "ebl_defs.svh"
`default_nettype none

module ebl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        notFull;
    logic                        notEmpty;
  } ebl_fifo_s;

  ebl_fifo_s q;
  ebl_fifo_s d;
  logic      push;
  logic      pop;

  assign inReady  = q.notFull;
  assign outValid = q.notEmpty;
  assign outData  = q.mem[q.rdPtr];

  // Pointer and flag update; flags kept registered so ready is a flop
  always_comb begin
    d    = q;
    push = inValid & q.notFull;
    pop  = outReady & q.notEmpty;
    if (push) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr        = AW'(q.wrPtr + 1'b1);
    end
    if (pop) begin
      d.rdPtr = AW'(q.rdPtr + 1'b1);
    end
    d.count    = (AW+1)'(q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    d.notFull  = d.count != (AW+1)'(DEPTH);
    d.notEmpty = d.count != '0;
    if (!rst_n) begin
      d          = '0;
      d.notFull  = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q <= d;
  end
endmodule

module ebl_bulk_access
  import ebl_pkg::*;
#(
  parameter int WORD_PROG_CYC = (`EBL_WORD_PROG_NS * `EBL_CLK_MHZ + 999) / 1000,
  parameter int ERASE_CYC     = `EBL_ERASE_MS * `EBL_CLK_MHZ * 1000
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Decoded command request
  input  wire logic                  cmdValid,
  input  wire ebl_cmd_e              cmdCode,
  input  wire logic [15:0]           cmdData,
  input  wire logic                  cmdPecOk,
  // Command answer
  output logic                       rspValid,
  output logic                       rspAck,
  output logic [15:0]                rspData,
  // Alert pin, active low
  output logic                       alertLineN,
  // Telemetry samples into the log buffer
  input  wire logic                  sampleValid,
  input  wire logic [`EBL_DATA_W-1:0] sampleData,
  output logic                       sampleReady,
  // Fault log control and status
  input  wire logic                  faultLatchOff,
  input  wire logic                  allChannelsFresh,
  input  wire logic                  logBlockReadDone,
  input  wire logic                  quickLogEn,
  output logic                       logHeld,
  output logic                       ramFrozen,
  output logic                       busyN
);
  localparam int LOG_PROG_CYC = WORD_PROG_CYC * `EBL_LOG_WORDS;

  typedef struct packed {
    logic [`EBL_USER_WORDS-1:0][15:0] userMem;
    logic [`EBL_LOG_WORDS-1:0][15:0]  logNvm;
    logic [`EBL_LOG_WORDS-1:0][15:0]  logRam;
    logic                             logHeld;
    logic                             ramFrozen;
    logic                             logWait;
    logic [3:0]                       logPtr;
    ebl_mode_e                        mode;
    ebl_key_e                         keyStage;
    logic [7:0]                       keyLast;
    logic [7:0]                       wipeLast;
    logic                             pecReq;
    logic                             wiped;
    logic [`EBL_PTR_W-1:0]            ptr;
    logic [31:0]                      busyCnt;
    logic                             busyN;
    logic                             alertN;
    logic                             rspValid;
    logic                             rspAck;
    logic [15:0]                      rspData;
  } ebl_state_s;

  ebl_state_s           q;
  ebl_state_s           d;
  logic                 fifoValid;
  logic [`EBL_DATA_W-1:0] fifoData;
  logic                 fifoTake;
  logic                 busyNow;
  logic                 startLog;

  // Outputs straight from the state register
  assign rspValid   = q.rspValid;
  assign rspAck     = q.rspAck;
  assign rspData    = q.rspData;
  assign alertLineN = q.alertN;
  assign logHeld    = q.logHeld;
  assign ramFrozen  = q.ramFrozen;
  assign busyN      = q.busyN;

  // Draining stalls during any memory access so samples back up in the FIFO
  assign fifoTake = q.busyN;

  ebl_fifo #(
    .WIDTH (`EBL_DATA_W),
    .DEPTH (`EBL_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (sampleValid),
    .inData   (sampleData),
    .inReady  (sampleReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoTake)
  );

  //--------------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------------
  // Memory effects apply at once; busy then covers the programming time
  always_comb begin
    d          = q;
    busyNow    = q.busyCnt != '0;
    startLog   = 1'b0;
    d.rspValid = 1'b0;
    if (busyNow) begin
      d.busyCnt = q.busyCnt - 32'h0000_0001;
    end

    // Log buffer refresh, discarded while frozen after a restore
    if (fifoValid && fifoTake && !q.ramFrozen) begin
      d.logRam[q.logPtr] = fifoData;
      if (fifoData > q.logRam[`EBL_LOG_PEAK_SLOT]) begin
        d.logRam[`EBL_LOG_PEAK_SLOT] = fifoData;
      end
      if (fifoData < q.logRam[`EBL_LOG_MIN_SLOT]) begin
        d.logRam[`EBL_LOG_MIN_SLOT] = fifoData;
      end
      d.logPtr = (q.logPtr == 4'(`EBL_LOG_WORDS - 1)) ? `EBL_LOG_FIRST_CYC : 4'(q.logPtr + 4'h1);
    end

    // Successful log block read releases the frozen buffer; placed ahead of
    // the command decode so a restore in the same cycle wins
    if (logBlockReadDone) begin
      d.ramFrozen = 1'b0;
    end

    if (cmdValid) begin
      d.rspValid = 1'b1;
      d.rspAck   = 1'b1;
      d.rspData  = 16'h0000;
      if (busyNow && cmdCode != EBL_CMD_STATE_RD) begin
        d.rspAck = 1'b0;
        d.alertN = 1'b0;
      end else begin
        case (cmdCode)
          EBL_CMD_STATE_RD: begin
            d.rspData[`EBL_STATE_BUSYN_BIT] = q.busyN;
            d.rspData[`EBL_STATE_HELD_BIT]  = q.logHeld;
            d.rspData[`EBL_STATE_FROZ_BIT]  = q.ramFrozen;
            if (!busyNow) begin
              d.alertN = 1'b1; // Reading status once idle releases the alert
            end
          end
          EBL_CMD_KEY_WR: begin
            d.keyLast  = cmdData[7:0];
            d.mode     = EBL_LOCKED;
            d.keyStage = EBL_KEY_IDLE;
            case (q.keyStage)
              EBL_KEY_IDLE: begin
                if (cmdData[7:0] == `EBL_KEY_OPEN) begin
                  d.keyStage = EBL_KEY_OPENED;
                end
              end
              EBL_KEY_OPENED: begin
                if (cmdData[7:0] == `EBL_KEY_RW_PECOPT || cmdData[7:0] == `EBL_KEY_RW_PECREQ) begin
                  d.mode   = EBL_UNLOCK_RW;
                  d.pecReq = cmdData[7:0] == `EBL_KEY_RW_PECREQ;
                  d.ptr    = '0;
                  d.wiped  = 1'b0;
                end else if (cmdData[7:0] == `EBL_KEY_RD_STEP) begin
                  d.keyStage = EBL_KEY_RDSTEP;
                end
              end
              EBL_KEY_RDSTEP: begin
                if (cmdData[7:0] == `EBL_KEY_RD_PECOPT || cmdData[7:0] == `EBL_KEY_RD_PECREQ) begin
                  d.mode   = EBL_UNLOCK_RD;
                  d.pecReq = cmdData[7:0] == `EBL_KEY_RD_PECREQ;
                  d.ptr    = '0;
                  d.wiped  = 1'b0;
                end
              end
              default: d.keyStage = EBL_KEY_IDLE;
            endcase
          end
          EBL_CMD_KEY_RD: begin
            d.rspData = (q.mode == EBL_LOCKED) ? 16'h0000 : {8'h00, q.keyLast};
          end
          EBL_CMD_WIPE_WR: begin
            d.wipeLast = cmdData[7:0];
            if (q.mode != EBL_UNLOCK_RW) begin
              d.rspAck   = 1'b0;
              d.mode     = EBL_LOCKED;
              d.keyStage = EBL_KEY_IDLE;
            end else if (q.pecReq && !cmdPecOk) begin
              d.rspAck = 1'b0;
            end else if (cmdData[7:0] == `EBL_WIPE_CODE) begin
              for (int i = 0; i < `EBL_USER_WORDS; i++) begin
                d.userMem[i] = `EBL_ERASED_WORD;
              end
              d.wiped   = 1'b1;
              d.ptr     = '0;
              d.busyCnt = 32'(ERASE_CYC);
            end else begin
              d.mode     = EBL_LOCKED;
              d.keyStage = EBL_KEY_IDLE;
            end
          end
          EBL_CMD_WIPE_RD: begin
            d.rspData = {8'h00, q.wipeLast};
          end
          EBL_CMD_WORD_WR: begin
            if (q.mode != EBL_UNLOCK_RW || !q.wiped) begin
              d.rspAck   = 1'b0;
              d.mode     = EBL_LOCKED;
              d.keyStage = EBL_KEY_IDLE;
            end else if (q.pecReq && !cmdPecOk) begin
              d.rspAck = 1'b0;
            end else if (q.ptr >= `EBL_PTR_W'(`EBL_USER_WORDS)) begin
              d.mode     = EBL_LOCKED;
              d.keyStage = EBL_KEY_IDLE;
            end else begin
              d.userMem[q.ptr[5:0]] = cmdData;
              d.ptr                 = `EBL_PTR_W'(q.ptr + 1'b1);
              d.busyCnt             = 32'(WORD_PROG_CYC);
            end
          end
          EBL_CMD_WORD_RD: begin
            if (q.mode == EBL_LOCKED) begin
              d.rspData = 16'h0000;
            end else if (q.pecReq && !cmdPecOk) begin
              d.rspAck = 1'b0;
            end else begin
              d.ptr = `EBL_PTR_W'(q.ptr + 1'b1);
              if (q.ptr == '0) begin
                d.rspData = `EBL_REV_WORD;
              end else if (q.ptr == `EBL_PTR_W'(1)) begin
                d.rspData = 16'(`EBL_USER_WORDS);
              end else if (q.ptr < `EBL_PTR_W'(`EBL_USER_WORDS + 2)) begin
                d.rspData = q.userMem[6'(q.ptr - `EBL_PTR_W'(2))];
              end else begin
                d.rspData  = 16'h0000;
                d.mode     = EBL_LOCKED;
                d.keyStage = EBL_KEY_IDLE;
                d.ptr      = q.ptr;
              end
            end
          end
          EBL_CMD_LOG_STORE: begin
            startLog = !q.logHeld;
          end
          EBL_CMD_LOG_RESTORE: begin
            d.logRam    = q.logNvm;
            d.ramFrozen = 1'b1;
            d.busyCnt   = 32'(LOG_PROG_CYC);
          end
          EBL_CMD_LOG_CLEAR: begin
            for (int i = 0; i < `EBL_LOG_WORDS; i++) begin
              d.logNvm[i] = `EBL_ERASED_WORD;
            end
            d.logHeld   = 1'b0;
            d.ramFrozen = 1'b0;
            d.logWait   = 1'b0;
            d.busyCnt   = 32'(LOG_PROG_CYC);
          end
          default: d.rspAck = 1'b0;
        endcase
      end
    end

    // Fault or store request arms a log transfer unless one is held
    if ((faultLatchOff || startLog) && !q.logHeld) begin
      d.logWait = 1'b1;
    end
    // Quick mode copies at once; otherwise wait for fresh readings
    if (d.logWait && !d.logHeld && d.busyCnt == '0 && (quickLogEn || allChannelsFresh)) begin
      d.logNvm  = d.logRam;
      d.logHeld = 1'b1;
      d.logWait = 1'b0;
      d.busyCnt = 32'(LOG_PROG_CYC);
    end

    d.busyN = d.busyCnt == '0;

    // Reset keeps memory contents and the held flag, as they are nonvolatile
    if (!rst_n) begin
      d             = '0;
      d.userMem     = q.userMem;
      d.logNvm      = q.logNvm;
      d.logHeld     = q.logHeld;
      d.mode        = EBL_LOCKED;
      d.keyStage    = EBL_KEY_IDLE;
      d.logPtr      = `EBL_LOG_FIRST_CYC;
      d.logRam[`EBL_LOG_MIN_SLOT] = `EBL_ERASED_WORD;
      d.busyN       = 1'b1;
      d.alertN      = 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= d;
  end
endmodule

`default_nettype wire

// ===== tb/ebl_bulk_access_properties.sv
// Assertion checker for the EEPROM bulk access controller.
// Assumes it is bound to ebl_bulk_access and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ebl_bulk_access_props
  import ebl_pkg::*;
#(
  parameter int WORD_PROG_CYC = 4,
  parameter int ERASE_CYC     = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Command and answer
  input wire logic        cmdValid,
  input wire ebl_cmd_e    cmdCode,
  input wire logic        rspValid,
  input wire logic        rspAck,
  input wire logic [15:0] rspData,
  input wire logic        alertLineN,
  // Log control and status
  input wire logic        faultLatchOff,
  input wire logic        logBlockReadDone,
  input wire logic        quickLogEn,
  input wire logic        logHeld,
  input wire logic        ramFrozen,
  input wire logic        busyN
);
  localparam int BUSY_MAX = ERASE_CYC + 16 * WORD_PROG_CYC + 4;
  int   busyCnt_q;
  logic clrArm_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Busy span counter and last-command-was-clear flag
  // ----
  always_ff @(posedge clk) begin
    busyCnt_q <= busyN ? 0 : busyCnt_q + 1;
    clrArm_q  <= cmdValid ? (cmdCode == EBL_CMD_LOG_CLEAR) : clrArm_q;
  end
  a_state_acked: assert property (cmdValid && cmdCode == EBL_CMD_STATE_RD |=> rspValid && rspAck)
    else $error("state read not acked");
  a_state_busy_bit: assert property (cmdValid && cmdCode == EBL_CMD_STATE_RD && !busyN |=> busyN || !rspData[6])
    else $error("state byte hides busy");
  a_busy_refused: assert property (cmdValid && !busyN && cmdCode != EBL_CMD_STATE_RD |=> rspValid && !rspAck && !alertLineN)
    else $error("command taken while busy");
  a_alert_held: assert property (!alertLineN && !(cmdValid && cmdCode == EBL_CMD_STATE_RD && busyN) |=> !alertLineN)
    else $error("alert released early");
  a_busy_span: assert property ($rose(busyN) |-> busyCnt_q >= WORD_PROG_CYC)
    else $error("busy shorter than one word");
  a_busy_bounded: assert property (!busyN |-> busyCnt_q < BUSY_MAX)
    else $error("busy never ends");
  a_held_sticky: assert property ($fell(logHeld) |-> clrArm_q)
    else $error("log held cleared without wipe");
  a_frozen_release: assert property ($fell(ramFrozen) |-> clrArm_q || $past(logBlockReadDone) || $past(logBlockReadDone, 2))
    else $error("ram thawed without cause");
  a_quick_store: assert property (cmdValid && cmdCode == EBL_CMD_LOG_STORE && quickLogEn && busyN && !logHeld |-> ##[1:4] (logHeld && !busyN))
    else $error("quick store late");
  a_fault_store: assert property (faultLatchOff && quickLogEn && busyN && !logHeld && !cmdValid |-> ##[1:4] logHeld)
    else $error("fault did not store log");
endmodule
bind ebl_bulk_access ebl_bulk_access_props #(.WORD_PROG_CYC(WORD_PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .rspValid(rspValid), .rspAck(rspAck),
  .rspData(rspData), .alertLineN(alertLineN), .faultLatchOff(faultLatchOff), .logBlockReadDone(logBlockReadDone),
  .quickLogEn(quickLogEn), .logHeld(logHeld), .ramFrozen(ramFrozen), .busyN(busyN));
`default_nettype wire

// ===== tb/ebl_host_model.sv
// Host model: issues one decoded command at a time and polls busy.
// Assumes the answer is registered one clock after the request is taken.
`timescale 1ns/1ps
`default_nettype none
module ebl_host_model
  import ebl_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Request
  output var logic         cmdValid,
  output var ebl_cmd_e     cmdCode,
  output var logic [15:0]  cmdData,
  output var logic         cmdPecOk,
  // Answer and status
  input  wire logic        rspValid,
  input  wire logic        rspAck,
  input  wire logic [15:0] rspData,
  input  wire logic        busyN
);
  // Idle request lines
  initial begin
    cmdValid = 1'b0;
    cmdCode  = EBL_CMD_OTHER;
    cmdData  = 16'h0000;
    cmdPecOk = 1'b0;
  end
  // One transfer; a missing answer shows as an unknown ack
  task automatic xf(input ebl_cmd_e c, input logic [15:0] d, input logic p, output logic a, output logic [15:0] r);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdCode  = c;
    cmdData  = d;
    cmdPecOk = p;
    @(posedge clk);
    #1;
    a = rspValid ? rspAck : 1'bx;
    r = rspData;
    @(negedge clk);
    cmdValid = 1'b0;
    cmdData  = ~cmdData; // Stale data must not look valid
    cmdPecOk = ~cmdPecOk;
  endtask
  // Poll busy instead of trusting fixed delays; bounded so a hang ends
  task automatic waitIdle();
    repeat (3) @(negedge clk);
    for (int i = 0; i < 200 && !busyN; i++) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/ebl_bulk_access_tb.sv
// Testbench for the EEPROM bulk access controller.
// Assumes shortened program and erase counts; sessions never mix reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ebl_bulk_access_tb
  import ebl_pkg::*;
;
  localparam logic [15:0] noData = 'x;
  logic clk = 1'b0;
  logic rst_n, cmdValid, cmdPecOk, rspValid, rspAck, alertLineN, sampleValid, sampleReady;
  logic faultLatchOff, allChannelsFresh, logBlockReadDone, quickLogEn, logHeld, ramFrozen, busyN;
  logic [15:0] cmdData, rspData, sampleData;
  ebl_cmd_e cmdCode;
  int errorCnt, checksDone;
  always #5 clk = ~clk;
  ebl_bulk_access #(.WORD_PROG_CYC(4), .ERASE_CYC(20)) u_dut (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .cmdPecOk(cmdPecOk),
    .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData), .alertLineN(alertLineN),
    .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady),
    .faultLatchOff(faultLatchOff), .allChannelsFresh(allChannelsFresh), .logBlockReadDone(logBlockReadDone),
    .quickLogEn(quickLogEn), .logHeld(logHeld), .ramFrozen(ramFrozen), .busyN(busyN));
  ebl_host_model u_host (
    .clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .cmdPecOk(cmdPecOk),
    .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData), .busyN(busyN));
  // ----
  // Comparison, command and verdict helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'd0, got}, {15'd0, exp});
  endtask
  // Skip the data compare when no value is expected
  task automatic t(input ebl_cmd_e k, input logic [15:0] d, input logic p, input logic ea, input logic [15:0] ed);
    logic a;
    logic [15:0] r;
    u_host.xf(k, d, p, a, r);
    chkb(a, ea);
    if (ed !== noData) chk(r, ed);
  endtask
  task automatic key(input logic [7:0] b);
    t(EBL_CMD_KEY_WR, {8'h00, b}, 1'b1, 1'b1, noData);
  endtask
  task automatic stopTest();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #200_000;
    errorCnt++;
    stopTest();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    errorCnt = 0;
    checksDone = 0;
    rst_n = 1'b0;
    sampleValid = 1'b0;
    sampleData = 16'h0000;
    faultLatchOff = 1'b0;
    allChannelsFresh = 1'b0;
    logBlockReadDone = 1'b0;
    quickLogEn = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // Nonvolatile log starts unknown, so wipe it first
    t(EBL_CMD_LOG_CLEAR, 16'h0000, 1'b1, 1'b1, noData);
    u_host.waitIdle();
    chkb(logHeld, 1'b0);
    // Locked part reads zero and refuses erase and writes
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    t(EBL_CMD_WIPE_WR, 16'h002B, 1'b1, 1'b0, noData);
    t(EBL_CMD_WORD_WR, 16'h1234, 1'b1, 1'b0, noData);
    key(8'h2B);
    key(8'h55);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    key(8'h2B);
    key(8'hD4);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b0, 1'b1, 16'h00D4);
    t(EBL_CMD_WIPE_WR, 16'h002B, 1'b0, 1'b1, noData);
    // While erasing only the state byte is answered
    t(EBL_CMD_STATE_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b0, noData);
    chkb(alertLineN, 1'b0);
    u_host.waitIdle();
    t(EBL_CMD_WIPE_RD, 16'h0000, 1'b1, 1'b1, 16'h002B);
    t(EBL_CMD_STATE_RD, 16'h0000, 1'b1, 1'b1, 16'h0040);
    chkb(alertLineN, 1'b1);
    // Fill every user word, then one write too many locks
    for (int i = 0; i < 64; i++) begin
      t(EBL_CMD_WORD_WR, 16'hA500 + 16'(i), 1'b1, 1'b1, noData);
      u_host.waitIdle();
    end
    t(EBL_CMD_WORD_WR, 16'h0BAD, 1'b1, 1'b1, noData);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    // Read-only session refuses an erase
    key(8'h2B);
    key(8'h91);
    key(8'hE4);
    t(EBL_CMD_WORD_RD, 16'h0000, 1'b0, 1'b1, 16'h0001);
    t(EBL_CMD_WIPE_WR, 16'h002B, 1'b1, 1'b0, noData);
    // Fresh unlock restarts the pointer; missing check byte refused
    key(8'h2B);
    key(8'h91);
    key(8'hE5);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h00E5);
    t(EBL_CMD_WORD_RD, 16'h0000, 1'b0, 1'b0, noData);
    t(EBL_CMD_WORD_RD, 16'h0000, 1'b1, 1'b1, 16'h0001);
    t(EBL_CMD_WORD_RD, 16'h0000, 1'b1, 1'b1, 16'd64);
    for (int i = 0; i < 64; i++) begin
      t(EBL_CMD_WORD_RD, 16'h0000, 1'b1, 1'b1, 16'hA500 + 16'(i));
    end
    t(EBL_CMD_WORD_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    // Mandatory check mode; any other wipe value locks
    key(8'h2B);
    key(8'hD5);
    t(EBL_CMD_WIPE_WR, 16'h002B, 1'b0, 1'b0, noData);
    t(EBL_CMD_WIPE_WR, 16'h0011, 1'b1, 1'b1, noData);
    t(EBL_CMD_WIPE_RD, 16'h0000, 1'b1, 1'b1, 16'h0011);
    t(EBL_CMD_KEY_RD, 16'h0000, 1'b1, 1'b1, 16'h0000);
    // Store the log while samples pile up behind the stalled drain
    t(EBL_CMD_LOG_STORE, 16'h0000, 1'b1, 1'b1, noData);
    for (int i = 0; i < 24; i++) begin
      sampleValid = 1'b1;
      sampleData = 16'h0100 + 16'(i);
      @(negedge clk);
    end
    sampleValid = 1'b0;
    chkb(sampleReady, 1'b0);
    u_host.waitIdle();
    chkb(logHeld, 1'b1);
    repeat (20) @(negedge clk);
    chkb(sampleReady, 1'b1);
    // Held log ignores a second store and survives reset
    t(EBL_CMD_LOG_STORE, 16'h0000, 1'b1, 1'b1, noData);
    repeat (3) @(negedge clk);
    chkb(busyN, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chkb(logHeld, 1'b1);
    // Restore freezes the buffer until a log block read
    t(EBL_CMD_LOG_RESTORE, 16'h0000, 1'b1, 1'b1, noData);
    u_host.waitIdle();
    chkb(ramFrozen, 1'b1);
    logBlockReadDone = 1'b1;
    @(negedge clk);
    logBlockReadDone = 1'b0;
    @(negedge clk);
    chkb(ramFrozen, 1'b0);
    // Slow fault store waits for fresh readings, quick one does not
    for (int q = 0; q < 2; q++) begin
      t(EBL_CMD_LOG_CLEAR, 16'h0000, 1'b1, 1'b1, noData);
      u_host.waitIdle();
      chkb(logHeld, 1'b0);
      quickLogEn = q[0];
      faultLatchOff = 1'b1;
      @(negedge clk);
      faultLatchOff = 1'b0;
      repeat (8) @(negedge clk);
      chkb(logHeld, q[0]);
      allChannelsFresh = 1'b1;
      @(negedge clk);
      allChannelsFresh = 1'b0;
      u_host.waitIdle();
      chkb(logHeld, 1'b1);
    end
    stopTest();
  end
endmodule
`default_nettype wire
